// ---- verilog/sdc_ctrl.sv ----
/*
 * Converter control and result logic: registers over Avalon-MM,
 * master clock divider, output-word timer, result hold and end flag.
 * Assumes the decimator delivers words synchronous to clk_i.
 */
`timescale 1ns/1ps
module sdc_ctrl #(
	parameter int DATA_W = 24
) (
	input wire logic clk_i, // System clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic [4:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [31:0] avs_writedata_i, // Write data
	input wire logic [3:0] avs_byteenable_i, // Byte enables
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Wait request
	input wire logic [DATA_W+1:0] filt_data_i, // Filter word, signed, with headroom
	input wire logic filt_valid_i, // Filter word strobe
	output logic mclk_en_o, // Master clock tick
	output logic word_tick_o, // Output word due
	output logic filt_rst_o, // Decimator reset
	output logic amp_on_o, // Amplifier power
	output logic conv_on_o, // Converter power
	output logic ref_ext_o, // External reference chosen
	output logic pos_buf_o, // Positive ref buffer enable
	output logic neg_buf_o, // Negative ref buffer enable
	output logic low_lat_o, // Low-latency mode
	output logic [14:0] osr_o, // Oversampling ratio
	output logic irq_req_o // Conversion end request pulse
);
	// Elaboration-time refusal of unsupported result widths
	if (DATA_W != 24) begin : g_bad_width
		$error("sdc_ctrl supports only 24-bit results");
	end

	logic [7:0] main_reg;
	logic [7:0] mode_reg;
	logic [7:0] clk_reg;
	logic [23:0] result_reg;
	logic rd_done_reg;
	logic frst_seen_reg;
	logic [5:0] mdiv_reg;
	logic [5:0] adiv_reg;
	logic [24:0] word_cnt_reg;
	logic [24:0] word_len_next;
	logic adc_tick;
	logic eoc_set;
	logic wr_main;
	logic wr_mode;
	logic wr_clk;
	sdc_pkg::sdc_mode_t mode_now;

	function automatic logic [23:0] sat24(input logic [25:0] v);
		if (!v[25] && v[24:23] != 2'b00) return sdc_pkg::SAT_POS;
		if (v[25] && v[24:23] != 2'b11) return sdc_pkg::SAT_NEG;
		return v[23:0];
	endfunction : sat24

	// Operating mode; power-down dominates
	always_comb begin
		if (main_reg[sdc_pkg::PDN_BIT]) mode_now = sdc_pkg::SDC_OFF;
		else if (main_reg[sdc_pkg::SLEEP_BIT]) mode_now = sdc_pkg::SDC_SLEEP;
		else if (main_reg[sdc_pkg::FRST_BIT]) mode_now = sdc_pkg::SDC_FRST;
		else mode_now = sdc_pkg::SDC_RUN;
	end

	always_comb begin
		amp_on_o = 1'b0;
		conv_on_o = 1'b0;
		filt_rst_o = 1'b1;
		unique case (mode_now)
			sdc_pkg::SDC_OFF: begin
			end
			sdc_pkg::SDC_SLEEP: amp_on_o = 1'b1;
			sdc_pkg::SDC_FRST: begin
				amp_on_o = 1'b1;
				conv_on_o = 1'b1;
			end
			sdc_pkg::SDC_RUN: begin
				amp_on_o = 1'b1;
				conv_on_o = 1'b1;
				filt_rst_o = !frst_seen_reg;
			end
		endcase
	end

	assign ref_ext_o = main_reg[sdc_pkg::REFSEL_BIT];
	assign pos_buf_o = mode_reg[sdc_pkg::PBUF_BIT];
	assign neg_buf_o = mode_reg[sdc_pkg::NBUF_BIT];
	assign low_lat_o = mode_reg[sdc_pkg::MODE_LSB+2];
	assign osr_o = sdc_pkg::OSR_MAX >> main_reg[sdc_pkg::RATE_LSB +: 3];

	// Data arrives only after a completed filter reset pulse
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) frst_seen_reg <= 1'b0;
		else if (mode_now == sdc_pkg::SDC_FRST) frst_seen_reg <= 1'b1;
		else if (mode_now == sdc_pkg::SDC_OFF) frst_seen_reg <= 1'b0;
	end

	// Master clock: system clock / 2 / (code+1), or bypass
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) mdiv_reg <= 6'h00;
		else if (!conv_on_o || mclk_en_o) mdiv_reg <= 6'h00;
		else mdiv_reg <= mdiv_reg + 6'h01;
	end
	assign mclk_en_o = (clk_reg[4:0] == sdc_pkg::CLK_BYPASS) ? conv_on_o :
		(conv_on_o && mdiv_reg == {clk_reg[4:0], 1'b1});

	// Converter clock: master clock / 30 or / 12
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !conv_on_o) adiv_reg <= 6'h00;
		else if (adc_tick) adiv_reg <= 6'h00;
		else if (mclk_en_o) adiv_reg <= adiv_reg + 6'h01;
	end
	assign adc_tick = mclk_en_o &&
		adiv_reg == (mode_reg[sdc_pkg::MODE_LSB+1] ? sdc_pkg::DIV_FAST : sdc_pkg::DIV_SLOW)
		- 6'h01;

	// Word period in converter clocks: factor_a * ratio
	assign word_len_next = low_lat_o ? {10'h000, osr_o} : {9'h000, osr_o, 1'b0};
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || filt_rst_o) word_cnt_reg <= 25'h0000000;
		else if (word_tick_o) word_cnt_reg <= 25'h0000000;
		else if (adc_tick) word_cnt_reg <= word_cnt_reg + 25'h0000001;
	end
	// Compare by magnitude so a shorter period set mid-count cannot wrap the counter
	assign word_tick_o = adc_tick && (word_cnt_reg >= word_len_next - 25'h0000001);

	// Result capture and end flag
	assign eoc_set = filt_valid_i && !filt_rst_o && !mode_reg[sdc_pkg::HOLD_BIT];
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) result_reg <= 24'h000000;
		else if (eoc_set) result_reg <= sat24(filt_data_i);
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) irq_req_o <= 1'b0;
		else irq_req_o <= eoc_set;
	end

	// Register writes
	assign wr_main = avs_write_i && avs_byteenable_i[0] && avs_address_i == sdc_pkg::OFS_CTL_MAIN;
	assign wr_mode = avs_write_i && avs_byteenable_i[0] && avs_address_i == sdc_pkg::OFS_CTL_MODE;
	assign wr_clk = avs_write_i && avs_byteenable_i[0] && avs_address_i == sdc_pkg::OFS_CLK_SEL;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) main_reg <= sdc_pkg::CTL_MAIN_RST;
		else if (wr_main) main_reg <= avs_writedata_i[7:0] & sdc_pkg::CTL_MAIN_MASK;
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) mode_reg <= sdc_pkg::CTL_MODE_RST;
		else begin
			if (wr_mode) mode_reg <= avs_writedata_i[7:0] & sdc_pkg::CTL_MODE_MASK;
			if (eoc_set) mode_reg[sdc_pkg::EOC_BIT] <= 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) clk_reg <= sdc_pkg::CLK_SEL_RST;
		else if (wr_clk) clk_reg <= avs_writedata_i[7:0] & sdc_pkg::CLK_SEL_MASK;
	end

	// Reads answer one cycle after request; writes take no wait
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) rd_done_reg <= 1'b0;
		else rd_done_reg <= avs_read_i && !rd_done_reg;
	end
	assign avs_waitrequest_o = avs_read_i && !rd_done_reg;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && !rd_done_reg) begin
			unique case (avs_address_i)
				sdc_pkg::OFS_RES_LOW: avs_readdata_o <= {24'h000000, result_reg[7:0]};
				sdc_pkg::OFS_RES_MID: avs_readdata_o <= {24'h000000, result_reg[15:8]};
				sdc_pkg::OFS_RES_HIGH: avs_readdata_o <= {24'h000000, result_reg[23:16]};
				sdc_pkg::OFS_CTL_MAIN: avs_readdata_o <= {24'h000000, main_reg};
				sdc_pkg::OFS_CTL_MODE: avs_readdata_o <= {24'h000000, mode_reg};
				sdc_pkg::OFS_CLK_SEL: avs_readdata_o <= {24'h000000, clk_reg};
				default: avs_readdata_o <= 32'h00000000;
			endcase
		end
	end

	AST_HOLD_FREEZE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_reg[sdc_pkg::HOLD_BIT] |=> $stable(result_reg))
		else $error("result changed while held");
	AST_HOLD_NO_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_reg[sdc_pkg::HOLD_BIT] && !wr_mode |=> !irq_req_o)
		else $error("request raised while held");
	AST_EOC_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		eoc_set |=> mode_reg[sdc_pkg::EOC_BIT] && irq_req_o)
		else $error("end flag or request missing");
	AST_PDN_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		main_reg[sdc_pkg::PDN_BIT] |-> !amp_on_o && !conv_on_o && !mclk_en_o)
		else $error("power-down not honoured");
	AST_SLEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!main_reg[sdc_pkg::PDN_BIT] && main_reg[sdc_pkg::SLEEP_BIT] |-> amp_on_o && !conv_on_o)
		else $error("sleep mode wrong");
	AST_FRST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_now == sdc_pkg::SDC_FRST |-> filt_rst_o && conv_on_o)
		else $error("filter reset mode wrong");
	AST_RUN_AFTER_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_now == sdc_pkg::SDC_FRST ##1 mode_now == sdc_pkg::SDC_RUN |-> !filt_rst_o)
		else $error("filter not released after pulse");
	AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!main_reg[1] && !mode_reg[0] && clk_reg[7:5] == 3'b000)
		else $error("unimplemented bit set");
	AST_SAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		eoc_set && !filt_data_i[25] && filt_data_i[24] |=> result_reg == sdc_pkg::SAT_POS)
		else $error("positive saturation missing");
	AST_OSR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		main_reg[4:2] == 3'b111 |-> osr_o == 15'h0080)
		else $error("ratio decode wrong");
	AST_NEG_SAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		eoc_set && filt_data_i[25] && !filt_data_i[24] |=> result_reg == sdc_pkg::SAT_NEG)
		else $error("negative saturation missing");
	AST_READ_WAIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("read answer late");
	AST_WRITE_NOWAIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		avs_write_i && !avs_read_i |-> !avs_waitrequest_o)
		else $error("write stalled");
	AST_READ_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		avs_readdata_o[31:8] == 24'h000000)
		else $error("read data upper bits set");
	AST_OFF_NO_TICK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!conv_on_o |-> !mclk_en_o && !word_tick_o)
		else $error("tick while converter halted");
	AST_BYPASS_TICK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		clk_reg[4:0] == sdc_pkg::CLK_BYPASS && conv_on_o |-> mclk_en_o)
		else $error("bypass clock missing");
	AST_MCLK_SPACING: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mclk_en_o && clk_reg[4:0] == 5'h00 && !wr_clk |=> !mclk_en_o)
		else $error("master clock faster than half");
	AST_IRQ_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		irq_req_o |-> $past(eoc_set))
		else $error("request without accepted word");
	AST_HOLD_EOC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_reg[sdc_pkg::HOLD_BIT] && !wr_mode |=> $stable(mode_reg[sdc_pkg::EOC_BIT]))
		else $error("end flag changed while held");
	AST_PDN_REARM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_now == sdc_pkg::SDC_OFF |=> filt_rst_o)
		else $error("filter not re-armed by power-down");
	AST_FRST_IGNORES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		filt_rst_o && filt_valid_i |=> $stable(result_reg))
		else $error("word taken during filter reset");
endmodule : sdc_ctrl

// ---- verilog/sdc_pkg.sv ----
/*
 * Constants for the delta-sigma converter control block: register map,
 * field positions, reset values and decode tables.
 * Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
 */
package sdc_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_RES_LOW = 5'h00;
	localparam logic [4:0] OFS_RES_MID = 5'h04;
	localparam logic [4:0] OFS_RES_HIGH = 5'h08;
	localparam logic [4:0] OFS_CTL_MAIN = 5'h0C;
	localparam logic [4:0] OFS_CTL_MODE = 5'h10;
	localparam logic [4:0] OFS_CLK_SEL = 5'h14;
	// Main control fields
	localparam int FRST_BIT = 7;
	localparam int SLEEP_BIT = 6;
	localparam int PDN_BIT = 5;
	localparam int RATE_LSB = 2;
	localparam int REFSEL_BIT = 0;
	localparam logic [7:0] CTL_MAIN_MASK = 8'hFD;
	localparam logic [7:0] CTL_MAIN_RST = 8'h20;
	// Mode control fields
	localparam int MODE_LSB = 5;
	localparam int NBUF_BIT = 4;
	localparam int PBUF_BIT = 3;
	localparam int HOLD_BIT = 2;
	localparam int EOC_BIT = 1;
	localparam logic [7:0] CTL_MODE_MASK = 8'hFE;
	localparam logic [7:0] CTL_MODE_RST = 8'h00;
	// Clock select
	localparam logic [7:0] CLK_SEL_MASK = 8'h1F;
	localparam logic [7:0] CLK_SEL_RST = 8'h00;
	localparam logic [4:0] CLK_BYPASS = 5'h1F;
	// Decode constants
	localparam logic [5:0] DIV_SLOW = 6'h1E;
	localparam logic [5:0] DIV_FAST = 6'h0C;
	localparam logic [14:0] OSR_MAX = 15'h4000;
	localparam logic [23:0] SAT_POS = 24'h7FFFFF;
	localparam logic [23:0] SAT_NEG = 24'h800000;

	typedef enum logic [1:0] {
		SDC_OFF,
		SDC_SLEEP,
		SDC_FRST,
		SDC_RUN
	} sdc_mode_t;
endpackage : sdc_pkg

// ---- verif/sdc_filt_model.sv ----
/*
 * Decimator word source feeding the converter control block.
 * Assumes the bench calls send from its own sequence, one word at a time.
 */
`timescale 1ns/1ps
module sdc_filt_model (
	input wire logic clk_i, // System clock
	output logic [25:0] data_o, // Filter word
	output logic valid_o // Word strobe
);
	initial begin
		data_o = 26'h0000000;
		valid_o = 1'b0;
	end
	task automatic send(input logic [25:0] w);
		@(posedge clk_i);
		data_o <= w;
		valid_o <= 1'b1;
		@(posedge clk_i);
		data_o <= ~w; // Stale word never repeats
		valid_o <= 1'b0;
	endtask : send
endmodule : sdc_filt_model

// ---- verif/tb_top.sv ----
/*
 * Self-checking bench for the converter control block.
 * Assumes the package offsets and a 200 MHz system clock.
 */
`timescale 1ns/1ps
module tb_top;
	logic clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, filt_valid_i;
	logic [4:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [25:0] filt_data_i;
	logic mclk_en_o, word_tick_o, filt_rst_o, amp_on_o, conv_on_o, ref_ext_o;
	logic pos_buf_o, neg_buf_o, low_lat_o, irq_req_o;
	logic [14:0] osr_o;
	int bad_count = 0, n_compared = 0, cyc = 0, irq_n = 0, tk;
	sdc_ctrl i_sdc_ctrl (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
		.filt_data_i, .filt_valid_i, .mclk_en_o, .word_tick_o, .filt_rst_o, .amp_on_o,
		.conv_on_o, .ref_ext_o, .pos_buf_o, .neg_buf_o, .low_lat_o, .osr_o, .irq_req_o);
	sdc_filt_model i_sdc_filt_model (.clk_i, .data_o(filt_data_i), .valid_o(filt_valid_i));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (irq_req_o === 1'b1) irq_n <= irq_n + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			stop_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h000000, d};
		avs_write_i <= 1'b1;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 1'b0;
		@(negedge clk_i);
	endtask : wr
	task automatic rdr(input logic [4:0] a);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_read_i <= 1'b1;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
	endtask : rdr
	task automatic t_reset();
		rdr(sdc_pkg::OFS_CTL_MAIN); chk("main", 32'h20, rd);
		rdr(sdc_pkg::OFS_CTL_MODE); chk("mode", 32'h00, rd);
		rdr(sdc_pkg::OFS_CLK_SEL); chk("clk", 32'h00, rd);
		rdr(5'h18); chk("unmapped", 32'h00, rd);
		chk("pwr", 3'b100, {filt_rst_o, amp_on_o, conv_on_o});
		$display("t_reset done");
	endtask : t_reset
	task automatic t_ctl();
		wr(sdc_pkg::OFS_CTL_MAIN, 8'hFF);
		chk("pwr_off", 2'b00, {amp_on_o, conv_on_o});
		rdr(sdc_pkg::OFS_CTL_MAIN); chk("main_rb", 32'hFD, rd);
		wr(sdc_pkg::OFS_CTL_MAIN, 8'h40);
		chk("sleep", 2'b10, {amp_on_o, conv_on_o});
		wr(sdc_pkg::OFS_CTL_MAIN, 8'h80); // Pulse filter reset after power-up
		chk("frst", 3'b111, {filt_rst_o, amp_on_o, conv_on_o});
		wr(sdc_pkg::OFS_CTL_MAIN, 8'h01);
		chk("run", 2'b01, {filt_rst_o, ref_ext_o});
		for (int i = 0; i < 8; i++) begin
			wr(sdc_pkg::OFS_CTL_MAIN, 8'(i << 2));
			chk("osr", 32'(16384 >> i), {17'h0, osr_o});
		end
		$display("t_ctl done");
	endtask : t_ctl
	task automatic t_mode();
		logic [7:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 8'(i << 6) | 8'h18;
			wr(sdc_pkg::OFS_CTL_MODE, m);
			chk("lowlat", {31'h0, m[7]}, {31'h0, low_lat_o});
			chk("bufs", 2'b11, {pos_buf_o, neg_buf_o});
			rdr(sdc_pkg::OFS_CTL_MODE); chk("mode_rb", {24'h0, m}, rd);
		end
		wr(sdc_pkg::OFS_CTL_MODE, 8'h00);
		$display("t_mode done");
	endtask : t_mode
	task automatic wrd(input logic [25:0] w, input logic [23:0] e, input int di);
		int n0;
		n0 = irq_n;
		i_sdc_filt_model.send(w);
		repeat (2) @(negedge clk_i);
		chk("irq", 32'(n0 + di), 32'(irq_n));
		rdr(sdc_pkg::OFS_RES_LOW); chk("low", {24'h0, e[7:0]}, rd);
		rdr(sdc_pkg::OFS_RES_MID); chk("mid", {24'h0, e[15:8]}, rd);
		rdr(sdc_pkg::OFS_RES_HIGH); chk("high", {24'h0, e[23:16]}, rd);
		rdr(sdc_pkg::OFS_CTL_MODE); chk("eoc", 32'(di << 1), rd & 32'h2);
	endtask : wrd
	task automatic t_word();
		wrd(26'h0123456, 24'h123456, 1);
		wr(sdc_pkg::OFS_CTL_MODE, 8'h00); // Software clears the end flag
		wrd(26'h1000000, sdc_pkg::SAT_POS, 1);
		wrd(26'h2000000, sdc_pkg::SAT_NEG, 1);
		wr(sdc_pkg::OFS_CTL_MODE, 8'h04); // Hold before reading
		wrd(26'h0000111, sdc_pkg::SAT_NEG, 0);
		wr(sdc_pkg::OFS_CTL_MODE, 8'h00);
		$display("t_word done");
	endtask : t_word
	task automatic t_clk();
		for (int c = 0; c < 2; c++) begin
			wr(sdc_pkg::OFS_CLK_SEL, c ? 8'hFF : 8'h01);
			tk = 0;
			repeat (40) begin
				@(negedge clk_i);
				if (mclk_en_o === 1'b1) tk++;
			end
			chk("mclk", c ? 32'd40 : 32'd10, 32'(tk));
		end
		rdr(sdc_pkg::OFS_CLK_SEL); chk("clk_rb", 32'h1F, rd);
		$display("t_clk done");
	endtask : t_clk
	task automatic t_tick();
		int n;
		for (int c = 0; c < 2; c++) begin
			wr(sdc_pkg::OFS_CTL_MODE, c ? 8'h40 : 8'hC0);
			n = 0;
			while (word_tick_o !== 1'b1) @(negedge clk_i);
			@(negedge clk_i);
			while (word_tick_o !== 1'b1 && n < 8000) begin
				n++;
				@(negedge clk_i);
			end
			chk("tick", c ? 32'd3071 : 32'd1535, 32'(n));
		end
		$display("t_tick done");
	endtask : t_tick
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	initial begin
		rst_n_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 5'h00;
		avs_writedata_i = 32'h00000000;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		t_reset();
		t_ctl();
		t_mode();
		t_word();
		t_clk();
		t_tick();
		stop_test();
	end
endmodule : tb_top
